// file: logic/scrc_top.sv
// System clock source selection and RC oscillator calibration control.
// Assumes oscillator ready inputs synchronous to CORE_CLK, APB master.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scrc_cfg.svh"

// Functional notes
// - Select bit 0 picks crystal, 1 RC
// - Switch only once new source is stable
// - Crystal-to-RC switch may wait for calibration
// - Power-down bit stops the unselected fast oscillator
// - Toggling select clears power-down bit
// - Selecting crystal starts one fast RC calibration
// - Calibration blocks RC switch, RC power-down, sleep
// - Keep calibrated value; power-down stops fast RC
// - Recalibrate fast RC after sleep on crystal
// - Deep sleep wake restores default RC trim
// - Slow RC target is crystal over 750/1500
// - Slow RC calibrates only with stable crystal
// - Reset selects slow RC; slow oscillators exclusive
// - Slow RC calibrates continuously on crystal
// - Non-initial calibration aborts on switch or sleep
// - Initial calibration finishes before switch or sleep
// - Later requests abort after 130 us delay
// - Fast RC stable flag reads at bit 5
module scrc_top
	import scrc_pkg::*;
#(
	parameter int   LPRC_CAL_CYCLES = `SCRC_LPRC_CAL_CYC,
	parameter int   ABORT_CYCLES    = `SCRC_ABORT_CYC,
	parameter bit   HS48_VARIANT    = 1'b0
) (
	// Clock, reset, enable
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic        CLK_EN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Oscillator status
	input  wire logic        XOSC_READY,
	input  wire logic        HFRC_READY,
	// Oscillator control
	output logic             XOSC_PWR_EN,
	output logic             HFRC_PWR_EN,
	output logic             SYS_CLK_SEL,
	output logic             HFRC_USE_CAL,
	output logic             HFRC_CAL_RUN,
	output logic             LPRC_CAL_RUN,
	output logic             LPRC_EN,
	output logic             SLOW_XTAL_EN,
	output logic [10:0]      LPRC_CAL_DIVISOR,
	output logic [2:0]       SYS_CLK_DIV,
	// Power mode handshake
	output logic             SLEEP_ENTER,
	output logic [1:0]       SLEEP_LEVEL,
	input  wire logic        WAKE
);
	localparam scrc_state_t ST_RST = '{
		seq: SEQ_RUN, req_osc: `SCRC_RST_OSC, cur_osc: `SCRC_RST_OSC,
		osc32k: `SCRC_RST_OSC32K, pd: `SCRC_RST_PD, pd_pend: 1'b0,
		div: `SCRC_RST_DIV, mode: `SCRC_RST_MODE, sleep_level: 2'h0,
		sleep_pulse: 1'b0, hfrc_trim_cal: 1'b0, hfrc_cal_pend: 1'b0,
		lprc_init: 1'b0, prdata: 32'h0000_0000
	};

	scrc_state_t st;
	scrc_state_t next_st;
	scrc_cal_if  cal ();

	logic xosc_pwr;
	logic hfrc_pwr;
	logic xstb;
	logic hstb;
	logic cal_any;
	logic apb_setup;
	logic apb_wr;
	logic addr_ok;

	scrc_cal_timer #(
		.CW        (17),
		.HFRC_CYC  (`SCRC_HFRC_CAL_CYC),
		.LPRC_CYC  (LPRC_CAL_CYCLES),
		.ABORT_CYC (ABORT_CYCLES)
	) i_scrc_cal_timer (
		.CORE_CLK (CORE_CLK),
		.ARST_N   (ARST_N),
		.cal      (cal)
	);

	// Unselected oscillator off only when power-down set and no change
	assign xosc_pwr = !st.cur_osc || !st.req_osc || !st.pd;
	assign hfrc_pwr = st.cur_osc || st.req_osc || !st.pd
		|| cal.hfrc_busy;
	assign xstb = xosc_pwr && XOSC_READY;
	assign hstb = hfrc_pwr && HFRC_READY;
	assign cal_any = cal.hfrc_busy || cal.lprc_busy;
	assign apb_setup = PSEL && !PENABLE;
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign addr_ok = PADDR == `SCRC_OFS_CLK_CTRL
		|| PADDR == `SCRC_OFS_SLEEP || PADDR == `SCRC_OFS_CAL_STAT;
	assign cal.clk_en = CLK_EN;

	always_comb
	begin
		next_st = st;
		next_st.sleep_pulse = 1'b0;
		cal.hfrc_start = 1'b0;
		cal.lprc_start = 1'b0;
		cal.lprc_abort = 1'b0;
		if (cal.hfrc_done)
			next_st.hfrc_trim_cal = 1'b1;
		if (cal.lprc_done)
			next_st.lprc_init = 1'b0;
		// Deferred power-down lands when calibration ends
		if (st.pd_pend && !cal_any)
		begin
			next_st.pd = 1'b1;
			next_st.pd_pend = 1'b0;
		end
		case (st.seq)
			SEQ_SWITCH:
			begin
				if (!st.req_osc)
				begin
					if (xstb)
					begin
						next_st.cur_osc = 1'b0;
						next_st.seq = SEQ_RUN;
						next_st.hfrc_cal_pend = 1'b0;
						cal.hfrc_start = 1'b1;
						if (st.osc32k)
						begin
							cal.lprc_start = 1'b1;
							next_st.lprc_init = 1'b1;
						end
					end
				end
				else if (cal.lprc_busy && !st.lprc_init)
					cal.lprc_abort = 1'b1;
				else if (!cal_any && hstb)
				begin
					next_st.cur_osc = 1'b1;
					next_st.seq = SEQ_RUN;
				end
			end
			SEQ_SLEEP:
			begin
				if (cal.lprc_busy && !st.lprc_init && !cal.hfrc_busy)
					cal.lprc_abort = 1'b1;
				else if (!cal_any)
				begin
					next_st.sleep_pulse = 1'b1;
					next_st.sleep_level = st.mode;
					next_st.mode = 2'h0;
					next_st.seq = SEQ_ASLEEP;
				end
			end
			SEQ_ASLEEP:
			begin
				if (WAKE)
				begin
					next_st.seq = SEQ_RUN;
					if (st.sleep_level[1])
						next_st.hfrc_trim_cal = 1'b0;
					if (!st.cur_osc)
						next_st.hfrc_cal_pend = 1'b1;
				end
			end
			SEQ_RUN:
			begin
				// Post-sleep recalibration waits for a stable crystal
				if (st.hfrc_cal_pend && !st.cur_osc && xstb)
				begin
					cal.hfrc_start = 1'b1;
					next_st.hfrc_cal_pend = 1'b0;
					if (st.osc32k && !cal.lprc_busy)
						cal.lprc_start = 1'b1;
				end
				else if (cal.lprc_done && !st.cur_osc && st.osc32k
					&& xstb)
					cal.lprc_start = 1'b1;
			end
			default:
				next_st.seq = SEQ_RUN;
		endcase
		// Register reads are captured in the setup phase
		if (apb_setup)
		begin
			case (PADDR)
				`SCRC_OFS_CLK_CTRL:
					next_st.prdata = {24'h000000, st.osc32k, st.cur_osc,
						3'h0, st.div};
				`SCRC_OFS_SLEEP:
					next_st.prdata = {25'h0000000, xstb, hstb, 2'h0,
						st.pd, st.mode};
				`SCRC_OFS_CAL_STAT:
					next_st.prdata = {27'h0000000, st.lprc_init,
						st.hfrc_trim_cal, st.seq != SEQ_RUN,
						cal.lprc_busy, cal.hfrc_busy};
				default:
					next_st.prdata = 32'h0000_0000;
			endcase
		end
		if (apb_wr && PADDR == `SCRC_OFS_CLK_CTRL)
		begin
			next_st.div = PWDATA[2:0];
			// Slow source is frozen while the crystal clocks the system
			if (st.cur_osc)
				next_st.osc32k = PWDATA[`SCRC_B_OSC32K];
			// New selections are ignored while a change is pending
			if (st.seq == SEQ_RUN && PWDATA[`SCRC_B_OSC] != st.req_osc)
			begin
				next_st.req_osc = PWDATA[`SCRC_B_OSC];
				next_st.seq = SEQ_SWITCH;
				next_st.pd = 1'b0;
				next_st.pd_pend = 1'b0;
			end
		end
		if (apb_wr && PADDR == `SCRC_OFS_SLEEP)
		begin
			if (!PWDATA[`SCRC_B_PD])
			begin
				next_st.pd = 1'b0;
				next_st.pd_pend = 1'b0;
			end
			else if (cal_any)
				next_st.pd_pend = 1'b1;
			else
				next_st.pd = 1'b1;
			if (st.seq == SEQ_RUN && PWDATA[1:0] != 2'h0)
			begin
				next_st.mode = PWDATA[1:0];
				next_st.seq = SEQ_SLEEP;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			st <= ST_RST;
		else if (CLK_EN)
			st <= next_st;
	end

	assign PRDATA = st.prdata;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
	assign XOSC_PWR_EN = xosc_pwr;
	assign HFRC_PWR_EN = hfrc_pwr;
	assign SYS_CLK_SEL = st.cur_osc;
	assign HFRC_USE_CAL = st.hfrc_trim_cal;
	assign HFRC_CAL_RUN = cal.hfrc_busy;
	assign LPRC_CAL_RUN = cal.lprc_busy;
	assign LPRC_EN = st.osc32k;
	assign SLOW_XTAL_EN = !st.osc32k;
	assign LPRC_CAL_DIVISOR = HS48_VARIANT ? `SCRC_LPRC_DIV_HS48
		: `SCRC_LPRC_DIV_STD;
	assign SYS_CLK_DIV = st.div;
	assign SLEEP_ENTER = st.sleep_pulse;
	assign SLEEP_LEVEL = st.sleep_level;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	chk_rc_stable: assert property ($rose(st.cur_osc) |-> $past(hstb))
		else $error("switched to RC before stable");
	chk_xtal_stable: assert property (
		$fell(st.cur_osc) |-> $past(xstb))
		else $error("switched to crystal before stable");
	chk_xtal_cal: assert property (
		$fell(st.cur_osc) |-> cal.hfrc_busy ##1 cal.hfrc_busy)
		else $error("no fast RC calibration on crystal");
	chk_rc_block: assert property (
		$rose(st.cur_osc) |-> $past(!cal.hfrc_busy && !cal.lprc_busy))
		else $error("RC switch during calibration");
	chk_sleep_block: assert property (
		SLEEP_ENTER |-> $past(!cal.hfrc_busy) && SLEEP_LEVEL != 2'h0)
		else $error("sleep entered during fast RC calibration");
	chk_toggle_pd: assert property (
		(CLK_EN && apb_wr && PADDR == `SCRC_OFS_CLK_CTRL
		&& st.seq == SEQ_RUN && PWDATA[`SCRC_B_OSC] != st.req_osc)
		|=> !st.pd && st.seq == SEQ_SWITCH)
		else $error("select toggle left power-down set");
	chk_pd_power: assert property (
		(st.pd && !st.cur_osc && !st.req_osc && !cal.hfrc_busy)
		|-> !HFRC_PWR_EN && XOSC_PWR_EN)
		else $error("unselected oscillator still powered");
	chk_both_run: assert property (
		!st.pd |-> XOSC_PWR_EN && HFRC_PWR_EN)
		else $error("oscillator off with power-down clear");
	chk_wake_trim: assert property (
		(CLK_EN && st.seq == SEQ_ASLEEP && WAKE && st.sleep_level[1])
		|=> !HFRC_USE_CAL)
		else $error("deep wake kept calibrated trim");
	chk_slow_excl: assert property (LPRC_EN != SLOW_XTAL_EN)
		else $error("slow oscillators both on or off");
	chk_lprc_xtal: assert property (
		cal.lprc_busy |-> !st.cur_osc)
		else $error("slow RC calibrating without crystal");
	chk_stb_bit: assert property (
		(CLK_EN && apb_setup && PADDR == `SCRC_OFS_SLEEP)
		|=> PRDATA[`SCRC_B_HSTB] == $past(hstb))
		else $error("fast RC stable flag misreported");

	cov_to_rc: cover property ($rose(st.cur_osc));
	cov_to_xtal: cover property ($fell(st.cur_osc));
	cov_sleep: cover property (SLEEP_ENTER);
	cov_abort: cover property (cal.lprc_abort && cal.lprc_busy);
endmodule
`default_nettype wire

// file: logic/scrc_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// clock-source controller. Assumes a 50 MHz core clock.
`ifndef SCRC_CFG_SVH
`define SCRC_CFG_SVH

`define SCRC_CLK_MHZ       50
`define SCRC_LPRC_CAL_US   2000
`define SCRC_ABORT_US      130
`define SCRC_HFRC_CAL_US   60
`define SCRC_LPRC_CAL_CYC  (`SCRC_LPRC_CAL_US * `SCRC_CLK_MHZ)
`define SCRC_ABORT_CYC     (`SCRC_ABORT_US * `SCRC_CLK_MHZ)
`define SCRC_HFRC_CAL_CYC  (`SCRC_HFRC_CAL_US * `SCRC_CLK_MHZ)

`define SCRC_OFS_CLK_CTRL  12'h000
`define SCRC_OFS_SLEEP     12'h004
`define SCRC_OFS_CAL_STAT  12'h008

`define SCRC_B_OSC32K      7
`define SCRC_B_OSC         6
`define SCRC_B_XSTB        6
`define SCRC_B_HSTB        5
`define SCRC_B_PD          2

`define SCRC_RST_OSC32K    1'b1
`define SCRC_RST_OSC       1'b1
`define SCRC_RST_PD        1'b1
`define SCRC_RST_DIV       3'h1
`define SCRC_RST_MODE      2'h0

`define SCRC_LPRC_DIV_STD  11'd750
`define SCRC_LPRC_DIV_HS48 11'd1500

`endif

// file: logic/scrc_pkg.sv
// Types of the clock-source controller.
// Assumes scrc_cfg.svh for all numeric constants.
`default_nettype none
package scrc_pkg;

	typedef enum logic [1:0] {
		SEQ_RUN    = 2'b00,
		SEQ_SWITCH = 2'b01,
		SEQ_SLEEP  = 2'b10,
		SEQ_ASLEEP = 2'b11
	} scrc_seq_t;

	typedef struct packed {
		scrc_seq_t   seq;
		logic        req_osc;
		logic        cur_osc;
		logic        osc32k;
		logic        pd;
		logic        pd_pend;
		logic [2:0]  div;
		logic [1:0]  mode;
		logic [1:0]  sleep_level;
		logic        sleep_pulse;
		logic        hfrc_trim_cal;
		logic        hfrc_cal_pend;
		logic        lprc_init;
		logic [31:0] prdata;
	} scrc_state_t;

endpackage
`default_nettype wire

// file: logic/scrc_cal_if.sv
// Link between the controller and its calibration timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface scrc_cal_if;
	logic clk_en;
	logic hfrc_start;
	logic lprc_start;
	logic lprc_abort;
	logic hfrc_busy;
	logic lprc_busy;
	logic hfrc_done;
	logic lprc_done;

	modport ctrl (
		output clk_en, hfrc_start, lprc_start, lprc_abort,
		input  hfrc_busy, lprc_busy, hfrc_done, lprc_done
	);
	modport timer (
		input  clk_en, hfrc_start, lprc_start, lprc_abort,
		output hfrc_busy, lprc_busy, hfrc_done, lprc_done
	);
endinterface
`default_nettype wire

// file: logic/scrc_cal_timer.sv
// Calibration timer: fast RC run, slow RC run and its abort delay.
// Assumes start and abort strobes come from the controller's clock.
`timescale 1ns/1ps
`default_nettype none
module scrc_cal_timer #(
	parameter int CW          = 17,
	parameter int HFRC_CYC    = 3000,
	parameter int LPRC_CYC    = 100000,
	parameter int ABORT_CYC   = 6500
) (
	// Clock and reset
	input  wire logic CORE_CLK,
	input  wire logic ARST_N,
	// Controller side
	scrc_cal_if.timer cal
);
	typedef struct packed {
		logic          hfrc_on;
		logic          lprc_on;
		logic          aborting;
		logic          hfrc_done;
		logic          lprc_done;
		logic [CW-1:0] hfrc_cnt;
		logic [CW-1:0] lprc_cnt;
		logic [CW-1:0] abort_cnt;
	} scrc_tmr_t;

	localparam scrc_tmr_t TMR_RST = '0;

	scrc_tmr_t st;
	scrc_tmr_t next_st;

	function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
		dec = v - {{(CW-1){1'b0}}, 1'b1};
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.hfrc_done = 1'b0;
		next_st.lprc_done = 1'b0;
		if (st.hfrc_on)
		begin
			next_st.hfrc_cnt = dec(st.hfrc_cnt);
			if (st.hfrc_cnt == '0)
			begin
				next_st.hfrc_on = 1'b0;
				next_st.hfrc_done = 1'b1;
			end
		end
		if (cal.hfrc_start)
		begin
			next_st.hfrc_on = 1'b1;
			next_st.hfrc_cnt = CW'(HFRC_CYC - 1);
		end
		if (st.lprc_on)
		begin
			next_st.lprc_cnt = dec(st.lprc_cnt);
			if (st.lprc_cnt == '0)
			begin
				next_st.lprc_on = 1'b0;
				next_st.aborting = 1'b0;
				next_st.lprc_done = 1'b1;
			end
			else if (st.aborting)
			begin
				// Abort lands only after the settle delay
				next_st.abort_cnt = dec(st.abort_cnt);
				if (st.abort_cnt == '0)
				begin
					next_st.lprc_on = 1'b0;
					next_st.aborting = 1'b0;
				end
			end
			else if (cal.lprc_abort)
			begin
				next_st.aborting = 1'b1;
				next_st.abort_cnt = CW'(ABORT_CYC - 1);
			end
		end
		if (cal.lprc_start)
		begin
			next_st.lprc_on = 1'b1;
			next_st.aborting = 1'b0;
			next_st.lprc_cnt = CW'(LPRC_CYC - 1);
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			st <= TMR_RST;
		else if (cal.clk_en)
			st <= next_st;
	end

	assign cal.hfrc_busy = st.hfrc_on;
	assign cal.lprc_busy = st.lprc_on;
	assign cal.hfrc_done = st.hfrc_done;
	assign cal.lprc_done = st.lprc_done;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	chk_abort_delay: assert property (
		(cal.clk_en && st.lprc_on && !st.aborting && cal.lprc_abort
		&& !cal.lprc_start && st.lprc_cnt > CW'(ABORT_CYC))
		|=> st.aborting && st.abort_cnt == CW'(ABORT_CYC - 1))
		else $error("abort delay not loaded");
endmodule
`default_nettype wire

// file: tb/scrc_top_tb.sv
// Self-checking bench of the clock-source controller.
// Assumes scrc_cfg.svh on the include path; bench is the APB master.
`timescale 1ns/1ps
`default_nettype none
`include "scrc_cfg.svh"
module scrc_top_tb;
	// Short counts keep the run brief
	localparam int LPRC_C  = 200;
	localparam int ABORT_C = 20;

	logic        clk     = 1'b0;
	logic        rst_n   = 1'b0;
	logic        clk_en  = 1'b1;
	logic        psel    = 1'b0;
	logic        pen     = 1'b0;
	logic        pwr     = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic        xrdy    = 1'b0;
	logic        hrdy    = 1'b0;
	logic        xok     = 1'b0;
	logic        wake    = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        xpwr;
	logic        hpwr;
	logic        sel;
	logic        uc;
	logic        hcal;
	logic        lcal;
	logic        lpen;
	logic        sxen;
	logic [10:0] ldiv;
	logic [2:0]  sdiv;
	logic        sent;
	logic [1:0]  slvl;
	logic [32:0] eq[$];
	logic [32:0] mq[$];
	int          bad_count = 0;
	int          cmp_count = 0;

	scrc_top #(
		.LPRC_CAL_CYCLES(LPRC_C),
		.ABORT_CYCLES   (ABORT_C),
		.HS48_VARIANT   (1'b0)
	) i_scrc_top (
		.CORE_CLK(clk), .ARST_N(rst_n), .CLK_EN(clk_en),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .XOSC_READY(xrdy), .HFRC_READY(hrdy),
		.XOSC_PWR_EN(xpwr), .HFRC_PWR_EN(hpwr), .SYS_CLK_SEL(sel),
		.HFRC_USE_CAL(uc), .HFRC_CAL_RUN(hcal), .LPRC_CAL_RUN(lcal),
		.LPRC_EN(lpen), .SLOW_XTAL_EN(sxen), .LPRC_CAL_DIVISOR(ldiv),
		.SYS_CLK_DIV(sdiv), .SLEEP_ENTER(sent), .SLEEP_LEVEL(slvl),
		.WAKE(wake)
	);

	always #10 clk = ~clk;

	// Fast RC reports stable one cycle after power, crystal only while xok is set; each drops one cycle after power goes off
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xrdy <= 1'b0;
			hrdy <= 1'b0;
		end
		else
		begin
			xrdy <= xpwr & xok;
			hrdy <= hpwr;
		end
	end

	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Entered just after a rising edge; leaves one edge after release
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	// Bit 32 of a note is the expected error response
	task automatic rd(input logic [11:0] a, input logic [32:0] e,
		input logic [32:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask

	always @(posedge clk)
	begin
		if (psel && pen && pready && !pwr && eq.size() > 0)
		begin
			chk({pslverr, prdata} & mq[0], eq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
	end

	function automatic logic sig(input int k);
		case (k)
			0: return sel;
			1: return hcal;
			2: return lcal;
			default: return sent;
		endcase
	endfunction

	// Bounded wait on a sampled output; overrun is a mismatch
	task automatic wt(input int k, input logic v, input int lim,
		output int n);
		n = 0;
		while (sig(k) !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk(n < lim, 1'b1);
	endtask

	initial
	begin
		int         n;
		int         hi;
		logic [2:0] d;
		void'($urandom(32'h78ee));
		// Divider drawn at random over its whole range of 0 to 7
		d = 3'($urandom_range(7, 0));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`SCRC_OFS_CLK_CTRL, 33'hc1, 33'h1000000ff);
		rd(`SCRC_OFS_SLEEP, 33'h24, 33'h100000067);
		rd(12'h00c, 33'h100000000, {33{1'b1}});
		chk({lpen, sxen, xpwr, hpwr, sel}, 5'b10011);
		chk(ldiv, 11'd750);
		// Crystal requested but held unstable
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b10000, d});
		repeat (30) @(posedge clk);
		chk({sel, xpwr}, 2'b11);
		chk(sdiv, d);
		rd(`SCRC_OFS_SLEEP, 33'h0, 33'h100000004);
		xok <= 1'b1;
		wt(0, 1'b0, 20, n);
		wt(1, 1'b1, 4, n);
		wt(2, 1'b1, 4, n);
		rd(`SCRC_OFS_CLK_CTRL, {25'h0, 5'b10000, d}, 33'h1000000ff);
		// One request back to the RC during the initial calibration
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b11000, d});
		wt(0, 1'b1, 4000, n);
		chk({hcal, lcal, uc}, 3'b001);
		chk(n > 2800, 1'b1);
		// Crystal again: slow calibration repeats
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b10000, d});
		wt(0, 1'b0, 20, n);
		wt(1, 1'b1, 4, n);
		wt(1, 1'b0, 3100, n);
		hi = 0;
		repeat (400)
		begin
			@(posedge clk);
			hi += lcal;
		end
		chk(hi > 390, 1'b1);
		rd(`SCRC_OFS_CAL_STAT, 33'h0, 33'h100000011);
		// Later request aborts the running calibration
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b11000, d});
		wt(0, 1'b1, ABORT_C + 10, n);
		chk(lcal, 1'b0);
		// Power-down while the RC is stable and selected
		apb(1'b1, `SCRC_OFS_SLEEP, 32'h4);
		chk({xpwr, hpwr}, 2'b01);
		rd(`SCRC_OFS_SLEEP, 33'h24, 33'h100000067);
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b01000, d});
		chk({lpen, sxen}, 2'b01);
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b11000, d});
		chk({lpen, sxen}, 2'b10);
		// Sleep levels requested while the fast calibration runs
		apb(1'b1, `SCRC_OFS_CLK_CTRL, {24'h0, 5'b10000, d});
		wt(0, 1'b0, 30, n);
		wt(1, 1'b1, 4, n);
		for (int l = 1; l < 4; l++)
		begin
			apb(1'b1, `SCRC_OFS_SLEEP, 32'(l));
			wt(3, 1'b1, 3500, n);
			chk({slvl, hcal}, {2'(l), 1'b0});
			repeat ($urandom_range(9, 1)) @(posedge clk);
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			repeat (3) @(posedge clk);
			chk(uc, l == 1);
			wt(1, 1'b1, 30, n);
		end
		// Power-down during the recalibration waits for its end
		apb(1'b1, `SCRC_OFS_SLEEP, 32'h4);
		rd(`SCRC_OFS_SLEEP, 33'h0, 33'h100000004);
		chk(hpwr, 1'b1);
		// Clock enable low must freeze the calibration timer
		clk_en <= 1'b0;
		repeat (3200) @(posedge clk);
		chk(hcal, 1'b1);
		clk_en <= 1'b1;
		wt(1, 1'b0, 3100, n);
		// Deferred power-down lands in the next slow calibration gap
		repeat (LPRC_C + 10) @(posedge clk);
		rd(`SCRC_OFS_SLEEP, 33'h4, 33'h100000004);
		chk({xpwr, hpwr, hcal}, 3'b100);
		chk(33'(eq.size()), 33'h0);
		stop_test();
	end

	// Whole run needs about 22000 cycles
	initial
	begin
		repeat (40000) @(posedge clk);
		bad_count++;
		stop_test();
	end
endmodule
`default_nettype wire
